// file: hdl/spread_output_config.sv
`timescale 1ns/1ns
`default_nettype none
`include "spread_defs.svh"
module spread_output_config (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [3:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    input wire logic DIV0_CLK,
    input wire logic DIV1_CLK,
    input wire logic STRAP_PIN_IN,
    output logic STRAP_PIN_OUT,
    output logic STRAP_PIN_OE,
    output logic FUSE_MODE,
    output logic [23:0] DIV0_NUMERATOR,
    output logic [6:0] DIV0_INTEGER,
    output logic [23:0] DIV1_NUMERATOR,
    output logic [6:0] DIV1_INTEGER,
    output logic PAIR_ONE_FIRST_OUTPUT,
    output logic PAIR_ONE_SECOND_OUTPUT,
    output logic PAIR_TWO_FIRST_OUTPUT,
    output logic PAIR_TWO_SECOND_OUTPUT
);
    ////////////////////////////////////////////////////////////////////////
    // register file
    logic [15:0] spread_control_reg, spread_control_next; // enable, profile, steps
    logic [15:0] spread_step_increment_reg, spread_step_increment_next;
    logic [15:0] pin_function_control_reg, pin_function_control_next;
    logic [15:0] spread_preset_config_reg, spread_preset_config_next;
    logic [15:0] device_control_reg, device_control_next; // power-down, fuse inhibit
    logic [6:0] div0_int_reg, div0_int_next;
    logic [23:0] div0_num_reg, div0_num_next;
    logic [6:0] div1_int_reg, div1_int_next;
    logic [23:0] div1_num_reg, div1_num_next;
    logic [15:0] rdata_reg, rdata_next;
    logic clk_valid_reg, clk_valid_next; // outputs settled after power-down release

    // register writes and read mux
    always_comb begin
        spread_control_next = spread_control_reg;
        spread_step_increment_next = spread_step_increment_reg;
        pin_function_control_next = pin_function_control_reg;
        spread_preset_config_next = spread_preset_config_reg;
        device_control_next = device_control_reg;
        div0_int_next = div0_int_reg;
        div0_num_next = div0_num_reg;
        div1_int_next = div1_int_reg;
        div1_num_next = div1_num_reg;
        rdata_next = rdata_reg;
        if (REG_WR) begin
            case (REG_ADDR)
                `OFS_SPREAD_CONTROL: spread_control_next = REG_WDATA;
                `OFS_SPREAD_STEP_INCREMENT: spread_step_increment_next = REG_WDATA;
                `OFS_PIN_FUNCTION_CONTROL: pin_function_control_next = REG_WDATA;
                `OFS_SPREAD_PRESET_CONFIG: spread_preset_config_next = REG_WDATA;
                `OFS_DEVICE_CONTROL: device_control_next = {14'h0000, REG_WDATA[1:0]};
                `OFS_DIV0_INT: div0_int_next = REG_WDATA[9:3];
                `OFS_DIV0_NUM_HI: div0_num_next[23:16] = REG_WDATA[15:8];
                `OFS_DIV0_NUM_LO: div0_num_next[15:0] = REG_WDATA;
                `OFS_DIV1_INT: div1_int_next = REG_WDATA[15:9];
                `OFS_DIV1_NUM_HI: div1_num_next[23:16] = REG_WDATA[12:5];
                `OFS_DIV1_NUM_LO: div1_num_next[15:0] = REG_WDATA;
                default: ; // unmapped writes are dropped
            endcase
        end
        if (REG_RD) begin
            case (REG_ADDR)
                `OFS_SPREAD_CONTROL: rdata_next = spread_control_reg;
                `OFS_SPREAD_STEP_INCREMENT: rdata_next = spread_step_increment_reg;
                `OFS_PIN_FUNCTION_CONTROL: rdata_next = pin_function_control_reg;
                `OFS_SPREAD_PRESET_CONFIG: rdata_next = spread_preset_config_reg;
                `OFS_DEVICE_CONTROL: rdata_next = {13'h0000, clk_valid_reg, device_control_reg[1:0]};
                `OFS_DIV0_INT: rdata_next = {6'h00, div0_int_reg, 3'h0};
                `OFS_DIV0_NUM_HI: rdata_next = {div0_num_reg[23:16], 8'h00};
                `OFS_DIV0_NUM_LO: rdata_next = div0_num_reg[15:0];
                `OFS_DIV1_INT: rdata_next = {div1_int_reg, 9'h000};
                `OFS_DIV1_NUM_HI: rdata_next = {3'h0, div1_num_reg[23:16], 5'h00};
                `OFS_DIV1_NUM_LO: rdata_next = div1_num_reg[15:0];
                default: rdata_next = 16'h0000; // unmapped reads return zero
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // spread modulator
    logic spread_enable;
    logic center_spread;
    logic [2:0] preset;
    logic [12:0] step_count;
    logic [15:0] step_inc;
    logic [12:0] step_reg, step_next;
    logic [23:0] offset_reg, offset_next; // numerator offset from base
    spread_pkg::sweep_e dir_reg, dir_next;
    logic [23:0] num_out_reg, num_out_next;
    logic [28:0] span; // full sweep height: step count times increment

    assign spread_enable = spread_control_reg[`BIT_SPREAD_ENABLE];
    assign center_spread = spread_control_reg[`BIT_PROFILE_SELECT];
    assign preset = spread_preset_config_reg[`PRESET_MSB:`PRESET_LSB];

    // preset table; depths assume a 200MHz divider output
    always_comb begin
        step_count = `PRESET_STEPS;
        step_inc = 16'h0000;
        case (preset)
            3'h0: begin
                step_count = spread_control_reg[`STEP_COUNT_MSB:`STEP_COUNT_LSB];
                step_inc = spread_step_increment_reg;
            end
            3'h1: step_inc = `PRESET_INC_1;
            3'h2: step_inc = `PRESET_INC_2;
            3'h3: step_inc = `PRESET_INC_3;
            3'h4: step_inc = `PRESET_INC_4;
            default: step_inc = 16'h0000; // reserved codes give no modulation
        endcase
    end

    assign span = {16'h0000, step_count} * {13'h0000, step_inc};

    // triangle sweep; held idle while powered down so reprogramming is clean
    always_comb begin
        step_next = step_reg;
        offset_next = offset_reg;
        dir_next = dir_reg;
        if (!spread_enable || device_control_reg[`BIT_POWER_DOWN] || step_count == 13'h0000) begin
            step_next = 13'h0000;
            offset_next = 24'h000000;
            dir_next = spread_pkg::SWEEP_UP;
        end else if (step_reg >= step_count - 13'h0001) begin
            step_next = 13'h0000;
            dir_next = (dir_reg == spread_pkg::SWEEP_UP) ? spread_pkg::SWEEP_DOWN
                                                         : spread_pkg::SWEEP_UP;
        end else begin
            step_next = step_reg + 13'h0001;
        end
        if (spread_enable && !device_control_reg[`BIT_POWER_DOWN] && step_count != 13'h0000) begin
            if (dir_reg == spread_pkg::SWEEP_UP)
                offset_next = offset_reg + {8'h00, step_inc};
            else
                offset_next = offset_reg - {8'h00, step_inc};
        end
        // down-spread raises divide ratio; center starts half a sweep lower
        if (center_spread)
            num_out_next = div0_num_reg + offset_reg - span[24:1];
        else
            num_out_next = div0_num_reg + offset_reg;
        if (!spread_enable)
            num_out_next = div0_num_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // pin function, reference clock, output pairs
    logic [3:0] settle_reg, settle_next;
    logic [2:0] ref_div_reg, ref_div_next;
    logic src_prev_reg, src_prev_next; // last sampled source level, for edge finding
    logic ref_clk_reg, ref_clk_next;
    logic pin_out_reg, pin_out_next, pin_oe_reg, pin_oe_next;
    logic strap_taken_reg, strap_taken_next, fuse_mode_reg, fuse_mode_next;
    spread_pkg::pair_out_s pair1_reg, pair1_next, pair2_reg, pair2_next;
    spread_pkg::pin_func_e pin_func;
    logic ref_src;

    assign pin_func = spread_pkg::pin_func_e'(pin_function_control_reg[`PIN_FUNC_MSB:`PIN_FUNC_LSB]);
    assign ref_src = pin_function_control_reg[`REFCLK_SRC_BIT] ? DIV1_CLK : DIV0_CLK;

    // pair format decode
    function automatic spread_pkg::pair_out_s fmt(input logic [2:0] code, input logic clk);
        spread_pkg::pair_out_s r;
        r = '0;
        case (code)
            3'h4: r.first = clk;
            3'h5: r.second = clk;
            3'h6: begin
                r.first = clk;
                r.second = ~clk;
            end
            3'h7: begin
                r.first = clk;
                r.second = clk;
            end
            default: r = '0; // reserved
        endcase
        return r;
    endfunction

    // strap capture, settle counter, pin mux
    always_comb begin
        strap_taken_next = 1'b1;
        fuse_mode_next = strap_taken_reg ? fuse_mode_reg : STRAP_PIN_IN;
        settle_next = settle_reg;
        if (device_control_reg[`BIT_POWER_DOWN])
            settle_next = 4'h0;
        else if (settle_reg != 4'(`SETTLE_CYCLES))
            settle_next = settle_reg + 4'h1;
        clk_valid_next = (settle_reg == 4'(`SETTLE_CYCLES));
        // count rising edges of the chosen divider, not core cycles
        src_prev_next = ref_src;
        ref_div_next = ref_div_reg;
        if (ref_src && !src_prev_reg)
            ref_div_next = ref_div_reg + 3'h1;
        case (pin_function_control_reg[`REFCLK_DIV_MSB:`REFCLK_DIV_LSB])
            2'h0: ref_clk_next = ref_div_reg[0];
            2'h1: ref_clk_next = ref_div_reg[1];
            default: ref_clk_next = ref_div_reg[2];
        endcase
        pin_out_next = 1'b0;
        pin_oe_next = strap_taken_reg;
        case (pin_func)
            spread_pkg::PIN_LOW: pin_out_next = 1'b0;
            spread_pkg::PIN_TRISTATE: pin_oe_next = 1'b0;
            spread_pkg::PIN_REFCLK: pin_out_next = ref_clk_reg;
            spread_pkg::PIN_VALID: pin_out_next = clk_valid_reg;
            default: pin_out_next = 1'b0;
        endcase
        pair1_next = fmt(pin_function_control_reg[`PAIR_ONE_FMT_MSB:`PAIR_ONE_FMT_LSB], DIV0_CLK);
        pair2_next = fmt(pin_function_control_reg[`PAIR_TWO_FMT_MSB:`PAIR_TWO_FMT_LSB], DIV0_CLK);
        if (!clk_valid_reg) begin
            pair1_next = '0;
            pair2_next = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // all state registers
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            spread_control_reg <= 16'h0000;
            spread_step_increment_reg <= 16'h0000;
            pin_function_control_reg <= `RESET_PIN_FUNC_CTRL | 16'h0E1C;
            spread_preset_config_reg <= 16'h0000;
            device_control_reg <= 16'h0000;
            div0_int_reg <= 7'h00;
            div0_num_reg <= 24'h000000;
            div1_int_reg <= 7'h00;
            div1_num_reg <= 24'h000000;
            rdata_reg <= 16'h0000;
            step_reg <= 13'h0000;
            offset_reg <= 24'h000000;
            dir_reg <= spread_pkg::SWEEP_UP;
            num_out_reg <= 24'h000000;
            clk_valid_reg <= 1'b0;
            settle_reg <= 4'h0;
            ref_div_reg <= 3'h0;
            src_prev_reg <= 1'b0;
            ref_clk_reg <= 1'b0;
            pin_out_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
            strap_taken_reg <= 1'b0;
            fuse_mode_reg <= 1'b0;
            pair1_reg <= '0;
            pair2_reg <= '0;
        end else begin
            spread_control_reg <= spread_control_next;
            spread_step_increment_reg <= spread_step_increment_next;
            pin_function_control_reg <= pin_function_control_next;
            spread_preset_config_reg <= spread_preset_config_next;
            device_control_reg <= device_control_next;
            div0_int_reg <= div0_int_next;
            div0_num_reg <= div0_num_next;
            div1_int_reg <= div1_int_next;
            div1_num_reg <= div1_num_next;
            rdata_reg <= rdata_next;
            step_reg <= step_next;
            offset_reg <= offset_next;
            dir_reg <= dir_next;
            num_out_reg <= num_out_next;
            clk_valid_reg <= clk_valid_next;
            settle_reg <= settle_next;
            ref_div_reg <= ref_div_next;
            src_prev_reg <= src_prev_next;
            ref_clk_reg <= ref_clk_next;
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
            strap_taken_reg <= strap_taken_next;
            fuse_mode_reg <= fuse_mode_next;
            pair1_reg <= pair1_next;
            pair2_reg <= pair2_next;
        end
    end

    assign REG_RDATA = rdata_reg;
    assign STRAP_PIN_OUT = pin_out_reg;
    assign STRAP_PIN_OE = pin_oe_reg;
    assign FUSE_MODE = fuse_mode_reg;
    assign DIV0_NUMERATOR = num_out_reg;
    assign DIV0_INTEGER = div0_int_reg;
    assign DIV1_NUMERATOR = div1_num_reg; // second divider never modulated
    assign DIV1_INTEGER = div1_int_reg;
    assign PAIR_ONE_FIRST_OUTPUT = pair1_reg.first;
    assign PAIR_ONE_SECOND_OUTPUT = pair1_reg.second;
    assign PAIR_TWO_FIRST_OUTPUT = pair2_reg.first;
    assign PAIR_TWO_SECOND_OUTPUT = pair2_reg.second;
endmodule
`default_nettype wire

// file: hdl/spread_defs.svh
// Function
// - spread applies only to spread-capable divider outputs
// - profile bit: 0 down, 1 center spread
// - preset codes custom, four depths, rest reserved
// - preset depths tuned for 200MHz divider
// - each step moves numerator by increment
// - pair format codes four/five drive one output
// - codes six antiphase, seven in phase
// - strap low serial mode, high fuse mode
// - reference clock from either divider, /2 /4 /8
// - pin function low, tristate, refclk, valid
// - divider is 7-bit integer plus 24-bit fraction
`ifndef SPREAD_DEFS_SVH
`define SPREAD_DEFS_SVH
`define OFS_SPREAD_CONTROL 4'h4
`define OFS_SPREAD_STEP_INCREMENT 4'h5
`define OFS_PIN_FUNCTION_CONTROL 4'h7
`define OFS_SPREAD_PRESET_CONFIG 4'h9
`define OFS_DIV0_INT 4'h0
`define OFS_DIV0_NUM_HI 4'h1
`define OFS_DIV0_NUM_LO 4'h2
`define OFS_DIV1_INT 4'h3
`define OFS_DIV1_NUM_HI 4'h6
`define OFS_DIV1_NUM_LO 4'h8
`define OFS_DEVICE_CONTROL 4'hA
`define BIT_SPREAD_ENABLE 0
`define BIT_PROFILE_SELECT 1
`define STEP_COUNT_LSB 2
`define STEP_COUNT_MSB 14
`define PRESET_LSB 9
`define PRESET_MSB 11
`define PAIR_ONE_FMT_LSB 2
`define PAIR_ONE_FMT_MSB 4
`define PAIR_TWO_FMT_LSB 9
`define PAIR_TWO_FMT_MSB 11
`define REFCLK_SRC_BIT 12
`define REFCLK_DIV_LSB 5
`define REFCLK_DIV_MSB 6
`define PIN_FUNC_LSB 13
`define PIN_FUNC_MSB 14
`define BIT_POWER_DOWN 0
`define BIT_FUSE_INHIBIT 1
`define RESET_PIN_FUNC_CTRL 16'h4000
`define RESET_PAIR_FMT 3'h7
`define PRESET_STEPS 13'h0C66
`define PRESET_INC_1 16'h00D4
`define PRESET_INC_2 16'h0213
`define PRESET_INC_3 16'h027D
`define PRESET_INC_4 16'h0428
`define SETTLE_NS 1000
`define CLK_NS 100
`define SETTLE_CYCLES ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// file: hdl/spread_pkg.sv
package spread_pkg;
    typedef enum logic [1:0] {PIN_LOW, PIN_TRISTATE, PIN_REFCLK, PIN_VALID} pin_func_e;
    typedef enum logic {SWEEP_UP, SWEEP_DOWN} sweep_e;
    typedef struct packed {
        logic first;
        logic second;
    } pair_out_s;
endpackage

// file: test/spread_checker.sv
`timescale 1ns/1ns
`default_nettype none
// watches the bus and pins; shadow copies of written words give the mode
module spread_checker (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [3:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic [15:0] REG_RDATA,
    input wire logic STRAP_PIN_IN,
    input wire logic STRAP_PIN_OUT,
    input wire logic STRAP_PIN_OE,
    input wire logic FUSE_MODE,
    input wire logic [23:0] DIV0_NUMERATOR,
    input wire logic [23:0] DIV1_NUMERATOR,
    input wire logic PAIR_ONE_FIRST_OUTPUT,
    input wire logic PAIR_ONE_SECOND_OUTPUT
);
logic [15:0] r4_reg, r5_reg, r7_reg, r9_reg; // shadow words
logic pd_reg, s7_reg, cap_reg; // power-down, word 7 seen, captured strap
logic [2:0] quiet_reg, age_reg; // cycles since a write, since reset
logic calm; // three quiet cycles: registered outputs have settled
assign calm = quiet_reg > 3'h2;
////////////////////////////////////////////////////////////////////////////////
// one process suffices here: helper state only, nothing drives the design
always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
        {r4_reg, r5_reg, r7_reg, r9_reg} <= 64'h0;
        {pd_reg, s7_reg, cap_reg} <= 3'h0;
        quiet_reg <= 3'h0;
        age_reg <= 3'h0;
    end else begin
        quiet_reg <= REG_WR ? 3'h0 : quiet_reg + {2'h0, quiet_reg != 3'h7};
        age_reg <= age_reg + {2'h0, age_reg != 3'h7};
        if (age_reg == 3'h0) cap_reg <= STRAP_PIN_IN;
        if (REG_WR) begin
            case (REG_ADDR)
                4'h4: r4_reg <= REG_WDATA;
                4'h5: r5_reg <= REG_WDATA;
                4'h7: r7_reg <= REG_WDATA;
                4'h9: r9_reg <= REG_WDATA;
                4'hA: pd_reg <= REG_WDATA[0];
                default: ;
            endcase
            if (REG_ADDR == 4'h7) s7_reg <= 1'b1;
        end
    end
end
////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge CORE_CLK); endclocking
default disable iff (!RST_N);
a_read_unmapped: assert property (REG_RD && REG_ADDR > 4'hA |=> REG_RDATA == 16'h0000)
    else $error("unmapped read not zero");
a_read_back: assert property (REG_RD && REG_ADDR == 4'h5 |=> REG_RDATA == $past(r5_reg))
    else $error("increment read back wrong");
a_plain_steady: assert property (calm |-> $stable(DIV1_NUMERATOR))
    else $error("plain divider numerator moved");
a_spread_off: assert property (calm && !r4_reg[0] |-> $stable(DIV0_NUMERATOR))
    else $error("numerator moved with spread off");
a_sweep_step: assert property (calm && r4_reg[0] && !pd_reg && r9_reg[11:9] == 3'h0 |->
    DIV0_NUMERATOR - $past(DIV0_NUMERATOR) == {8'h00, r5_reg} ||
    $past(DIV0_NUMERATOR) - DIV0_NUMERATOR == {8'h00, r5_reg})
    else $error("sweep step not the increment");
a_first_only: assert property (calm && s7_reg && r7_reg[4:2] == 3'h4 |->
    !PAIR_ONE_SECOND_OUTPUT) else $error("second output active");
a_second_only: assert property (calm && s7_reg && r7_reg[4:2] == 3'h5 |->
    !PAIR_ONE_FIRST_OUTPUT) else $error("first output active");
a_antiphase: assert property (calm && s7_reg && r7_reg[4:2] == 3'h6 |->
    !(PAIR_ONE_FIRST_OUTPUT && PAIR_ONE_SECOND_OUTPUT)) else $error("pair not antiphase");
a_in_phase: assert property (calm && s7_reg && r7_reg[4:2] == 3'h7 |->
    PAIR_ONE_FIRST_OUTPUT == PAIR_ONE_SECOND_OUTPUT) else $error("pair not in phase");
a_pin_low: assert property (calm && s7_reg && r7_reg[14:13] == 2'h0 |->
    STRAP_PIN_OE && !STRAP_PIN_OUT) else $error("pin not forced low");
a_pin_float: assert property (calm && s7_reg && r7_reg[14:13] == 2'h1 |->
    !STRAP_PIN_OE) else $error("pin not released");
a_strap_kept: assert property (age_reg > 3'h1 |-> FUSE_MODE == cap_reg)
    else $error("mode differs from strap");
endmodule
bind spread_output_config spread_checker i_spread_checker (.CORE_CLK(CORE_CLK),
    .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .STRAP_PIN_IN(STRAP_PIN_IN),
    .STRAP_PIN_OUT(STRAP_PIN_OUT), .STRAP_PIN_OE(STRAP_PIN_OE), .FUSE_MODE(FUSE_MODE),
    .DIV0_NUMERATOR(DIV0_NUMERATOR), .DIV1_NUMERATOR(DIV1_NUMERATOR),
    .PAIR_ONE_FIRST_OUTPUT(PAIR_ONE_FIRST_OUTPUT),
    .PAIR_ONE_SECOND_OUTPUT(PAIR_ONE_SECOND_OUTPUT));
`default_nettype wire

// file: test/spread_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// host on the far side of the register bus
module spread_host_model (
    input wire logic CORE_CLK,
    output logic REG_WR,
    output logic REG_RD,
    output logic [3:0] REG_ADDR,
    output logic [15:0] REG_WDATA,
    input wire logic [15:0] REG_RDATA
);
initial begin
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 4'h0;
    REG_WDATA = 16'h0000;
end
// one pulse per word; data inverted after so nothing leans on stale data
task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CORE_CLK);
    #1;
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(posedge CORE_CLK);
    #1;
    REG_WR = 1'b0;
    REG_WDATA = ~d;
endtask
// read data stands until the next read, so take it a cycle later
task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge CORE_CLK);
    #1;
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(posedge CORE_CLK);
    #1;
    REG_RD = 1'b0;
    @(posedge CORE_CLK);
    #1;
    d = REG_RDATA;
endtask
task automatic cfg(input logic [3:0] a, input logic [15:0] d);
    wr(4'hA, 16'h0001);
    wr(a, d);
    wr(4'hA, 16'h0000);
endtask
// enable goes after every other spread word is in place; power-down is released last
task automatic ssc_setup(input logic prof, input logic [2:0] pre, input logic [12:0] st,
    input logic [15:0] inc);
    wr(4'hA, 16'h0001);
    wr(4'hA, 16'h0003);
    wr(4'h9, {4'h0, pre, 9'h000});
    wr(4'h5, inc);
    wr(4'h4, {1'b0, st, prof, 1'b0});
    wr(4'h4, {1'b0, st, prof, 1'b1});
    wr(4'hA, 16'h0002);
endtask
endmodule
`default_nettype wire

// file: test/spread_output_config_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "spread_defs.svh"
module spread_output_config_bench;
logic core_clk = 1'b0;
logic rst_n = 1'b0;
logic div0_clk = 1'b0;
logic div1_clk = 1'b0;
logic strap_lvl = 1'b0; // level the board resistor puts on the strap pin
wire logic reg_wr, reg_rd, pin_in, pin_out, pin_oe, fuse_mode;
wire logic [3:0] reg_addr;
wire logic [3:0] pair; // pair one first, second, pair two first, second
wire logic [15:0] reg_wdata, reg_rdata;
wire logic [23:0] num0, num1;
wire logic [6:0] int0, int1;
int n_fail = 0;
int total_checks = 0;
always #50 core_clk = ~core_clk;
// divider clocks move just after a core edge, never on it
always #150 div0_clk <= #1 ~div0_clk;
always #250 div1_clk <= #1 ~div1_clk;
assign pin_in = pin_oe ? pin_out : strap_lvl;
spread_host_model i_spread_host_model (.CORE_CLK(core_clk), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata));
spread_output_config i_spread_output_config (.CORE_CLK(core_clk), .RST_N(rst_n),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .DIV0_CLK(div0_clk), .DIV1_CLK(div1_clk), .STRAP_PIN_IN(pin_in),
    .STRAP_PIN_OUT(pin_out), .STRAP_PIN_OE(pin_oe), .FUSE_MODE(fuse_mode),
    .DIV0_NUMERATOR(num0), .DIV0_INTEGER(int0), .DIV1_NUMERATOR(num1), .DIV1_INTEGER(int1),
    .PAIR_ONE_FIRST_OUTPUT(pair[3]), .PAIR_ONE_SECOND_OUTPUT(pair[2]),
    .PAIR_TWO_FIRST_OUTPUT(pair[1]), .PAIR_TWO_SECOND_OUTPUT(pair[0]));
task automatic chk(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
        n_fail++;
        $display("MISMATCH %0t %s", $time, what);
    end
endtask
task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
endtask
task automatic do_reset(input logic lvl);
    strap_lvl = lvl;
    rst_n = 1'b0;
    tick(16);
    rst_n = 1'b1;
    tick(4);
endtask
function automatic logic fmt_ok(int c, int a, int b, int s);
    case (c)
        4: return a > 0 && b == 0;
        5: return a == 0 && b > 0;
        6: return s == 0;
        default: return s == 24 && a > 0;
    endcase
endfunction
////////////////////////////////////////////////////////////////////////////////
task automatic t_reset();
    logic [15:0] d;
    i_spread_host_model.rd(4'h7, d);
    chk(d[14:13] === 2'h2, "pin function default");
    chk(d[4:2] === 3'h7 && d[11:9] === 3'h7, "format default");
    i_spread_host_model.rd(4'hF, d);
    chk(d === 16'h0000, "unmapped read");
    i_spread_host_model.wr(4'hA, 16'h0001);
    i_spread_host_model.wr(4'h0, 16'h0148);
    i_spread_host_model.wr(4'h3, 16'hA600);
    i_spread_host_model.wr(4'h6, 16'h1FE0);
    i_spread_host_model.wr(4'h8, 16'h1234);
    i_spread_host_model.wr(4'hA, 16'h0000);
    tick(1);
    chk(int0 === 7'h29 && int1 === 7'h53, "integer parts");
    chk(num1 === 24'hFF1234 && num0 === 24'h000000, "plain numerator");
    chk(fuse_mode === 1'b0, "serial mode strap");
    do_reset(1'b1);
    chk(fuse_mode === 1'b1, "fuse mode strap");
    do_reset(1'b0);
    $display("test reset done");
endtask
// pair format codes four to seven, both pairs watched over whole clock periods
task automatic t_formats();
    int cnt[6];
    for (int c = 4; c < 8; c++) begin
        // antiphase is swept as well as in phase, the preferred dual setting
        i_spread_host_model.cfg(4'h7, 16'h4000 | 16'(c << 9) | 16'(c << 2));
        tick(20);
        cnt = '{default: 0};
        repeat (24) begin
            tick(1);
            chk(^pair !== 1'bx, "pair unknown");
            cnt[0] += pair[3];
            cnt[1] += pair[2];
            cnt[2] += int'(pair[3] == pair[2]);
            cnt[3] += pair[1];
            cnt[4] += pair[0];
            cnt[5] += int'(pair[1] == pair[0]);
        end
        chk(fmt_ok(c, cnt[0], cnt[1], cnt[2]), "pair one format");
        chk(fmt_ok(c, cnt[3], cnt[4], cnt[5]), "pair two format");
    end
    $display("test formats done");
endtask
task automatic t_pin();
    int t[2];
    logic p;
    i_spread_host_model.cfg(4'h7, 16'h0E1C);
    tick(4);
    chk(pin_oe === 1'b1 && pin_out === 1'b0, "pin forced low");
    i_spread_host_model.cfg(4'h7, 16'h2E1C);
    tick(4);
    chk(pin_oe === 1'b0, "pin released");
    // halve the fast divider, then divide the slow one by eight
    for (int k = 0; k < 2; k++) begin
        i_spread_host_model.cfg(4'h7, 16'h4E1C | 16'(k * 16'h1040));
        tick(20);
        t[k] = 0;
        repeat (48) begin
            p = pin_out;
            tick(1);
            t[k] += int'(pin_out !== p);
        end
    end
    chk(pin_oe === 1'b1 && t[1] > 0 && t[0] > 2 * t[1], "reference clock divide");
    i_spread_host_model.cfg(4'h7, 16'h6E1C);
    chk(pin_oe === 1'b1 && pin_out === 1'b0, "ready too early");
    for (int i = 0; i < 30 && pin_out !== 1'b1; i++) tick(1);
    chk(pin_out === 1'b1, "ready never rose");
    if (pin_out !== 1'b1) end_sim();
    $display("test pin done");
endtask
// custom down, custom center, then the four presets
task automatic t_spread();
    logic [15:0] inc_t[4] = '{`PRESET_INC_1, `PRESET_INC_2, `PRESET_INC_3, `PRESET_INC_4};
    logic [23:0] lo, hi, prev, n1;
    logic [15:0] ic, d;
    logic [12:0] st;
    int bad;
    i_spread_host_model.wr(4'hA, 16'h0001);
    i_spread_host_model.wr(4'h1, 16'h8000);
    i_spread_host_model.wr(4'h2, 16'h0000);
    for (int p = 0; p < 6; p++) begin
        st = p < 2 ? 13'h0008 : `PRESET_STEPS;
        ic = p < 2 ? 16'h0010 : inc_t[p - 2];
        i_spread_host_model.ssc_setup(p == 1, p < 2 ? 3'h0 : 3'(p - 1), st, ic);
        i_spread_host_model.rd(4'h5, d);
        chk(d === ic, "increment read back");
        n1 = num1;
        lo = num0;
        hi = num0;
        bad = 0;
        repeat (2 * st + 4) begin
            prev = num0;
            tick(1);
            bad += int'(num0 - prev !== 24'(ic) && prev - num0 !== 24'(ic));
            if (num0 < lo) lo = num0;
            if (num0 > hi) hi = num0;
        end
        chk(bad == 0 && hi - lo === 24'(int'(st) * int'(ic)), "sweep");
        chk(num1 === n1, "plain divider moved");
        chk(p == 1 ? lo < 24'h800000 && hi > 24'h800000 :
            lo === 24'h800000 || hi === 24'h800000, "spread profile");
    end
    i_spread_host_model.cfg(4'h4, 16'h0000);
    tick(3);
    chk(num0 === 24'h800000, "spread off");
    $display("test spread done");
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    do_reset(1'b0);
    t_reset();
    t_formats();
    t_pin();
    t_spread();
    end_sim();
end
// a hang is cut short well past the longest expected run
initial begin
    #10000000;
    chk(1'b0, "run timed out");
    end_sim();
end
endmodule
`default_nettype wire
